// ---- design/fpsr_pkg.sv ----
package fpsr_pkg;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned DEBOUNCE_MS     = 5;
  localparam int unsigned BLINK_HZ        = 1;
  localparam int unsigned REBOOT_DELAY_S  = 10;
  localparam int unsigned HOLD_SHORT_S    = 1;
  localparam int unsigned HOLD_USER_S     = 10;
  localparam int unsigned HOLD_FACTORY_S  = 20;
  localparam int unsigned DEBOUNCE_CYC    = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int unsigned BLINK_HALF_CYC  = CLK_HZ / (2 * BLINK_HZ);
  localparam int unsigned SEC_CYC         = CLK_HZ;

  // ==========================================================================
  // apb register map
  // ==========================================================================
  localparam logic [7:0]  ADDR_STATUS   = 8'h00;
  localparam logic [7:0]  ADDR_IRQ_STAT = 8'h04;
  localparam logic [7:0]  ADDR_IRQ_MASK = 8'h08;
  localparam logic [7:0]  ADDR_CONTROL  = 8'h0c;
  localparam logic [31:0] APB_ZERO      = 32'h0000_0000;

  // event bit positions, shared by irq status and mask
  localparam int unsigned EV_SHORT   = 0;
  localparam int unsigned EV_OPEN    = 1;
  localparam int unsigned EV_HWRST   = 2;
  localparam int unsigned EV_USER    = 3;
  localparam int unsigned EV_FACTORY = 4;
  localparam int unsigned EV_W       = 5;
  localparam logic [EV_W-1:0] EV_ZERO = 5'h00;

  // control bits
  localparam int unsigned CTL_USER_SAVED = 0;

  // ==========================================================================
  // sync source states
  // ==========================================================================
  typedef enum logic [2:0] {
    SYNC_LOCKED              = 3'h0,
    SYNC_LOCKED_HOLDOVER     = 3'h1,
    SYNC_LOCKED_SIMULATED    = 3'h2,
    SYNC_OSC_REQUALIFYING    = 3'h3,
    SYNC_OSC_EXTERNALLY_SET  = 3'h4,
    SYNC_OSC_MANUALLY_SET    = 3'h5,
    SYNC_NO_VALID_TIME       = 3'h6
  } fpsr_sync_t;

  typedef enum logic [1:0] {
    ACT_NONE,
    ACT_HWRST,
    ACT_USER,
    ACT_FACTORY
  } fpsr_act_t;

endpackage

// ---- design/fpsr_top.sv ----
// How it works
// RULE1: speed led off at 10, on at 100
// RULE2: link led off without link, on idle
// RULE3: link led flashes on lan traffic
// RULE4: locked: red off, green on
// RULE5: holdover running: red off, green flashes
// RULE6: simulation mode: red flashes, green on
// RULE7: requalifying: both leds flash
// RULE8: oscillator externally set: both on
// RULE9: oscillator manually set: red on, green flashes
// RULE10: no valid time: red on, green off
// RULE11: separate antenna short and open faults
// RULE12: under 1 s ignored, 1-9 s hardware reset
// RULE13: 10-19 s user restore, reboot 10 s later
// RULE14: 20 s or more factory restore, reboot later
// RULE15: no saved user set means factory restore
// RULE16: debounce button before timing the hold
// RULE17: one shared blink source for all flashing
`timescale 1ns/1ns
`default_nettype none
module fpsr_top
  import fpsr_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC,
  parameter int unsigned BLINK_CYCLES    = BLINK_HALF_CYC,
  parameter int unsigned SECOND_CYCLES   = SEC_CYC,
  parameter int unsigned REBOOT_SECONDS  = REBOOT_DELAY_S
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        phy_link_up,
  input  wire logic        phy_speed_100,
  input  wire logic        phy_activity,
  input  wire logic [2:0]  sync_state,
  input  wire logic        antenna_short,
  input  wire logic        antenna_open,
  input  wire logic        button_n,
  output var  logic        speed_indicator,
  output var  logic        link_activity_indicator,
  output var  logic        red_status_indicator,
  output var  logic        green_status_indicator,
  output var  logic        antenna_short_fault,
  output var  logic        antenna_open_fault,
  output var  logic        hw_reset_pulse,
  output var  logic        user_preset_restore,
  output var  logic        factory_restore,
  output var  logic        reboot_pulse,
  output var  logic        irq
);

  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        speed;
    logic        link;
    logic        red;
    logic        green;
    logic        ant_short;
    logic        ant_open;
    logic        hw_rst;
    logic        user_rst;
    logic        fact_rst;
    logic        reboot;
    logic        irq;
    logic        blink;
    logic [31:0] blink_cnt;
    logic        btn_raw;
    logic        btn_stable;
    logic [31:0] deb_cnt;
    logic [31:0] sec_cnt;
    logic [7:0]  hold_s;
    logic        reboot_pend;
    logic [31:0] reboot_sec_cnt;
    logic [7:0]  reboot_s;
    logic [EV_W-1:0] ev_stat;
    logic [EV_W-1:0] ev_mask;
    logic        user_saved;
  } fpsr_state_t;

  fpsr_state_t s_r;
  fpsr_state_t s_nxt;

  function automatic fpsr_act_t hold_action(input logic [7:0] secs,
                                            input logic       saved);
    fpsr_act_t a;
    a = ACT_NONE;
    if (secs >= 8'(HOLD_FACTORY_S))
      a = ACT_FACTORY; // RULE14
    else if (secs >= 8'(HOLD_USER_S))
      a = saved ? ACT_USER : ACT_FACTORY; // RULE13 RULE15
    else if (secs >= 8'(HOLD_SHORT_S))
      a = ACT_HWRST; // RULE12
    return a;
  endfunction

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb
  begin
    fpsr_act_t        act;
    logic [EV_W-1:0]  ev_set;
    logic             apb_acc;
    logic             btn_pressed;
    act         = ACT_NONE;
    ev_set      = EV_ZERO;
    apb_acc     = psel && penable && !s_r.pready;
    btn_pressed = !button_n;
    s_nxt       = s_r;
    s_nxt.hw_rst   = 1'b0;
    s_nxt.user_rst = 1'b0;
    s_nxt.fact_rst = 1'b0;
    s_nxt.reboot   = 1'b0;

    // shared blink keeps every flashing led in phase
    if (s_r.blink_cnt >= BLINK_CYCLES - 1)
    begin
      s_nxt.blink_cnt = 32'h0;
      s_nxt.blink     = !s_r.blink; // RULE17
    end
    else
      s_nxt.blink_cnt = s_r.blink_cnt + 32'h1;

    s_nxt.speed = phy_speed_100; // RULE1
    if (!phy_link_up)
      s_nxt.link = 1'b0; // RULE2
    else if (phy_activity)
      s_nxt.link = s_r.blink; // RULE3
    else
      s_nxt.link = 1'b1; // RULE2

    case (fpsr_sync_t'(sync_state))
      SYNC_LOCKED:
      begin
        s_nxt.red   = 1'b0; // RULE4
        s_nxt.green = 1'b1;
      end
      SYNC_LOCKED_HOLDOVER:
      begin
        s_nxt.red   = 1'b0; // RULE5
        s_nxt.green = s_r.blink;
      end
      SYNC_LOCKED_SIMULATED:
      begin
        s_nxt.red   = s_r.blink; // RULE6
        s_nxt.green = 1'b1;
      end
      SYNC_OSC_REQUALIFYING:
      begin
        s_nxt.red   = s_r.blink; // RULE7
        s_nxt.green = s_r.blink;
      end
      SYNC_OSC_EXTERNALLY_SET:
      begin
        s_nxt.red   = 1'b1; // RULE8
        s_nxt.green = 1'b1;
      end
      SYNC_OSC_MANUALLY_SET:
      begin
        s_nxt.red   = 1'b1; // RULE9
        s_nxt.green = s_r.blink;
      end
      default:
      begin
        s_nxt.red   = 1'b1; // RULE10
        s_nxt.green = 1'b0;
      end
    endcase

    s_nxt.ant_short = antenna_short; // RULE11
    s_nxt.ant_open  = antenna_open; // RULE11
    ev_set[EV_SHORT] = antenna_short && !s_r.ant_short;
    ev_set[EV_OPEN]  = antenna_open && !s_r.ant_open;

    // debounce: level must hold for the full window before it counts
    s_nxt.btn_raw = btn_pressed;
    if (btn_pressed != s_r.btn_raw)
      s_nxt.deb_cnt = 32'h0;
    else if (s_r.deb_cnt >= DEBOUNCE_CYCLES - 1)
      s_nxt.btn_stable = s_r.btn_raw; // RULE16
    else
      s_nxt.deb_cnt = s_r.deb_cnt + 32'h1;

    // hold timer saturates so very long presses stay factory restores
    if (s_r.btn_stable)
    begin
      if (s_r.sec_cnt >= SECOND_CYCLES - 1)
      begin
        s_nxt.sec_cnt = 32'h0;
        if (s_r.hold_s != 8'hff)
          s_nxt.hold_s = s_r.hold_s + 8'h1; // RULE12
      end
      else
        s_nxt.sec_cnt = s_r.sec_cnt + 32'h1;
    end
    else
    begin
      s_nxt.sec_cnt = 32'h0;
      s_nxt.hold_s  = 8'h0;
    end

    if (s_r.btn_stable && !s_nxt.btn_stable)
      act = hold_action(s_r.hold_s, s_r.user_saved);
    case (act)
      ACT_HWRST:
      begin
        s_nxt.hw_rst = 1'b1; // RULE12
        ev_set[EV_HWRST] = 1'b1;
      end
      ACT_USER:
      begin
        s_nxt.user_rst    = 1'b1; // RULE13
        s_nxt.reboot_pend = 1'b1;
        s_nxt.reboot_sec_cnt = 32'h0;
        s_nxt.reboot_s    = 8'h0;
        ev_set[EV_USER]   = 1'b1;
      end
      ACT_FACTORY:
      begin
        s_nxt.fact_rst    = 1'b1; // RULE14 RULE15
        s_nxt.reboot_pend = 1'b1;
        s_nxt.reboot_sec_cnt = 32'h0;
        s_nxt.reboot_s    = 8'h0;
        ev_set[EV_FACTORY] = 1'b1;
      end
      default:
      begin
      end
    endcase

    if (s_r.reboot_pend && act == ACT_NONE)
    begin
      if (s_r.reboot_sec_cnt >= SECOND_CYCLES - 1)
      begin
        s_nxt.reboot_sec_cnt = 32'h0;
        if (s_r.reboot_s >= 8'(REBOOT_SECONDS - 1))
        begin
          s_nxt.reboot      = 1'b1; // RULE13 RULE14
          s_nxt.reboot_pend = 1'b0;
        end
        else
          s_nxt.reboot_s = s_r.reboot_s + 8'h1;
      end
      else
        s_nxt.reboot_sec_cnt = s_r.reboot_sec_cnt + 32'h1;
    end

    // apb: one wait state, answer on the second access cycle
    s_nxt.pready  = apb_acc;
    s_nxt.pslverr = 1'b0;
    s_nxt.prdata  = APB_ZERO;
    if (apb_acc)
    begin
      if (paddr == ADDR_STATUS)
      begin
        if (pwrite)
          s_nxt.pslverr = 1'b1;
        else
          s_nxt.prdata = {22'h0, s_r.btn_stable, s_r.reboot_pend,
                          s_r.ant_open, s_r.ant_short, sync_state,
                          s_r.link, phy_link_up, s_r.speed};
      end
      else if (paddr == ADDR_IRQ_STAT)
      begin
        if (pwrite)
          s_nxt.ev_stat = s_r.ev_stat & ~pwdata[EV_W-1:0];
        else
          s_nxt.prdata = {27'h0, s_r.ev_stat};
      end
      else if (paddr == ADDR_IRQ_MASK)
      begin
        if (pwrite)
          s_nxt.ev_mask = pwdata[EV_W-1:0];
        else
          s_nxt.prdata = {27'h0, s_r.ev_mask};
      end
      else if (paddr == ADDR_CONTROL)
      begin
        if (pwrite)
          s_nxt.user_saved = pwdata[CTL_USER_SAVED]; // RULE15
        else
          s_nxt.prdata = {31'h0, s_r.user_saved};
      end
      else
        s_nxt.pslverr = 1'b1;
    end
    // a new event wins over a simultaneous clear
    s_nxt.ev_stat = s_nxt.ev_stat | ev_set;
    s_nxt.irq     = |(s_nxt.ev_stat & s_nxt.ev_mask);
  end

  // ==========================================================================
  // registers
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign prdata                  = s_r.prdata;
  assign pready                  = s_r.pready;
  assign pslverr                 = s_r.pslverr;
  assign speed_indicator         = s_r.speed;
  assign link_activity_indicator = s_r.link;
  assign red_status_indicator    = s_r.red;
  assign green_status_indicator  = s_r.green;
  assign antenna_short_fault     = s_r.ant_short;
  assign antenna_open_fault      = s_r.ant_open;
  assign hw_reset_pulse          = s_r.hw_rst;
  assign user_preset_restore     = s_r.user_rst;
  assign factory_restore         = s_r.fact_rst;
  assign reboot_pulse            = s_r.reboot;
  assign irq                     = s_r.irq;

endmodule
`default_nettype wire

// ---- testbench/fpsr_top_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
module fpsr_top_asserts
  import fpsr_pkg::*;
#(
  parameter int unsigned SECOND_CYCLES  = 20,
  parameter int unsigned REBOOT_SECONDS = 2
)(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       phy_link_up,
  input wire logic       phy_speed_100,
  input wire logic       phy_activity,
  input wire logic [2:0] sync_state,
  input wire logic       antenna_short,
  input wire logic       antenna_open,
  input wire logic       speed_indicator,
  input wire logic       link_activity_indicator,
  input wire logic       red_status_indicator,
  input wire logic       green_status_indicator,
  input wire logic       antenna_short_fault,
  input wire logic       antenna_open_fault,
  input wire logic       hw_reset_pulse,
  input wire logic       user_preset_restore,
  input wire logic       factory_restore,
  input wire logic       reboot_pulse
);
  // ==========================================================================
  // properties
  // ==========================================================================
  // reboot lands exactly SECOND_CYCLES * REBOOT_SECONDS cycles on; window allows 3 either side
  localparam int RB_LO = SECOND_CYCLES * REBOOT_SECONDS - 3;
  localparam int RB_HI = SECOND_CYCLES * REBOOT_SECONDS + 3;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // outputs of the first edge after release still hold reset values
  a_speed_led: assert property (
    $past(presetn) |-> speed_indicator == $past(phy_speed_100))
    else $error("speed led wrong");
  a_link_dark: assert property (
    $past(presetn) && !$past(phy_link_up) |-> !link_activity_indicator)
    else $error("link lit");
  a_link_idle: assert property (
    $past(presetn) && $past(phy_link_up) && !$past(phy_activity)
    |-> link_activity_indicator)
    else $error("idle link dark");
  a_lock_leds: assert property (
    $past(presetn) && $past(sync_state) == 3'h0 |-> !red_status_indicator
    && green_status_indicator) else $error("locked leds wrong");
  a_ext_leds: assert property (
    $past(presetn) && $past(sync_state) == 3'h4 |-> red_status_indicator
    && green_status_indicator) else $error("ext set leds wrong");
  a_invalid_leds: assert property (
    $past(presetn) && $past(sync_state) >= 3'h6 |-> red_status_indicator
    && !green_status_indicator) else $error("invalid leds wrong");
  a_blink_phase: assert property (
    $past(presetn) && $past(sync_state) == 3'h3 |-> red_status_indicator
    == green_status_indicator) else $error("blink out of phase");
  a_ant_faults: assert property (
    $past(presetn) |-> antenna_short_fault == $past(antenna_short)
    && antenna_open_fault == $past(antenna_open)) else $error("fault lag");
  a_one_action: assert property (
    $onehot0({hw_reset_pulse, user_preset_restore, factory_restore}))
    else $error("two actions at once");
  a_reboot_due: assert property (
    user_preset_restore || factory_restore |-> ##[RB_LO:RB_HI] reboot_pulse)
    else $error("reboot missing");
  a_apb_answer: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer timing");
  a_err_with_ready: assert property (
    pslverr |-> pready) else $error("pslverr without pready");
endmodule
bind fpsr_top fpsr_top_asserts #(
  .SECOND_CYCLES(SECOND_CYCLES), .REBOOT_SECONDS(REBOOT_SECONDS)
) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .phy_link_up(phy_link_up),
  .phy_speed_100(phy_speed_100), .phy_activity(phy_activity),
  .sync_state(sync_state), .antenna_short(antenna_short),
  .antenna_open(antenna_open), .speed_indicator(speed_indicator),
  .link_activity_indicator(link_activity_indicator),
  .red_status_indicator(red_status_indicator),
  .green_status_indicator(green_status_indicator),
  .antenna_short_fault(antenna_short_fault),
  .antenna_open_fault(antenna_open_fault),
  .hw_reset_pulse(hw_reset_pulse),
  .user_preset_restore(user_preset_restore),
  .factory_restore(factory_restore), .reboot_pulse(reboot_pulse)
);
`default_nettype wire

// ---- testbench/fpsr_panel_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module fpsr_panel_model (
  input  wire logic pclk,
  input  wire logic press,
  output var  logic button_n
);
  // ==========================================================================
  // bouncing push button
  // ==========================================================================
  // contacts chatter for two cycles on every change, shorter than debounce
  logic       last_r = 1'b0;
  logic [1:0] bnc_r  = 2'h0;
  always_ff @(posedge pclk)
  begin
    if (press != last_r)
    begin
      last_r <= press;
      bnc_r  <= 2'h2;
    end
    else if (bnc_r != 2'h0)
      bnc_r <= bnc_r - 2'h1;
  end
  assign button_n = (bnc_r != 2'h0) ? (bnc_r[0] ^ last_r) : !last_r;
endmodule
`default_nettype wire

// ---- testbench/front_panel_status_and_reset_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module front_panel_status_and_reset_tb_top;
  import fpsr_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, press;
  logic link, spd, act, a_sh, a_op, btn, spd_l, lnk_l, red, grn, f_sh, f_op;
  logic hw, us, fa, rb;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] sst;
  logic e;
  logic [3:0] tbl [8] = '{4'h1, 4'h2, 4'h9, 4'ha, 4'h5, 4'h6, 4'h4, 4'h4};
  int n_errors, num_checks, cyc, c_hw, c_us, c_fa, c_rb;
  fpsr_top #(.DEBOUNCE_CYCLES(4), .BLINK_CYCLES(4), .SECOND_CYCLES(20),
    .REBOOT_SECONDS(2)) fpsr_top_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phy_link_up(link), .phy_speed_100(spd), .phy_activity(act),
    .sync_state(sst), .antenna_short(a_sh), .antenna_open(a_op),
    .button_n(btn), .speed_indicator(spd_l), .link_activity_indicator(lnk_l),
    .red_status_indicator(red), .green_status_indicator(grn),
    .antenna_short_fault(f_sh), .antenna_open_fault(f_op),
    .hw_reset_pulse(hw), .user_preset_restore(us), .factory_restore(fa),
    .reboot_pulse(rb), .irq(irq));
  fpsr_panel_model fpsr_panel_model_inst (.pclk(pclk), .press(press),
    .button_n(btn));
  // ==========================================================================
  // tasks
  // ==========================================================================
  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // this wait ends on pready, or at the bench timeout if pready never comes
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // led code over a window: 0 dark, 1 lit, 2 flashing
  task automatic scan(output logic [3:0] rg, output logic [1:0] lk);
    int r, g, l;
    r = 0; g = 0; l = 0;
    repeat (3) @(posedge pclk);
    repeat (16)
    begin
      @(posedge pclk);
      r += red; g += grn; l += lnk_l;
    end
    rg = {2'(r == 0 ? 0 : r == 16 ? 1 : 2), 2'(g == 0 ? 0 : g == 16 ? 1 : 2)};
    lk = 2'(l == 0 ? 0 : l == 16 ? 1 : 2);
  endtask
  // hold the button, release, compare actions taken
  task automatic hold(input int c, input logic [3:0] x);
    int s0, s1, s2, s3;
    s0 = c_hw; s1 = c_us; s2 = c_fa; s3 = c_rb;
    press <= 1'b1;
    repeat (c) @(posedge pclk);
    press <= 1'b0;
    repeat (80) @(posedge pclk);
    chk({4'(c_rb - s3), 4'(c_fa - s2), 4'(c_us - s1), 4'(c_hw - s0)},
        {3'h0, x[3], 3'h0, x[2], 3'h0, x[1], 3'h0, x[0]});
  endtask
  always @(posedge pclk)
  begin
    c_hw += hw; c_us += us; c_fa += fa; c_rb += rb;
    if (++cyc == 30000)
    begin
      n_errors++;
      close_out();
    end
  end
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // ==========================================================================
  // sequence
  // ==========================================================================
  initial
  begin
    logic [3:0] rg;
    logic [1:0] lk;
    {presetn, psel, penable, pwrite, press, link, spd, act, a_sh, a_op} = '0;
    paddr = 8'h00; pwdata = 32'h0; sst = 3'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_IRQ_MASK, 32'h0); chk(rd, 32'h0);
    apb(1'b0, ADDR_CONTROL, 32'h0); chk(rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0); chk(e, 1'b1);
    apb(1'b1, ADDR_STATUS, 32'hff); chk(e, 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      sst <= 3'(i);
      scan(rg, lk);
      chk(rg, tbl[i]);
    end
    for (int i = 0; i < 4; i++)
    begin
      {link, act} <= 2'(i);
      spd <= i[0];
      scan(rg, lk);
      chk(lk, i < 2 ? 0 : i == 2 ? 1 : 2);
      chk(spd_l, i[0]);
    end
    apb(1'b1, ADDR_IRQ_MASK, 32'h1f);
    a_sh <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({f_sh, f_op, irq}, 3'h5);
    apb(1'b1, ADDR_IRQ_STAT, 32'h1);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0); chk(rd, 32'h0);
    chk(irq, 1'b0);
    apb(1'b1, ADDR_IRQ_MASK, 32'h0);
    a_op <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({f_op, irq}, 2'h2);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0); chk(rd, 32'h2);
    hold(10, 4'h0);
    hold(110, 4'h1);
    hold(310, 4'hc);
    apb(1'b1, ADDR_CONTROL, 32'h1);
    hold(310, 4'ha);
    hold(210, 4'ha);
    hold(510, 4'hc);
    sst <= 3'h2;
    act <= 1'b0;
    apb(1'b0, ADDR_IRQ_STAT, 32'h0); chk(rd, 32'h1e);
    apb(1'b0, ADDR_STATUS, 32'h0); chk(rd, 32'h0000_00d7);
    close_out();
  end
endmodule
`default_nettype wire
